// ==== ccms_pkg.sv ====
// Package with constants and types for the CPU clock mode select block.
`default_nettype none

package ccms_pkg;

    // ****************************************************************
    // Mode codes and reset values
    // ****************************************************************
    localparam logic [2:0] MODE_RST    = 3'h7;
    localparam logic [2:0] CODE_PRESC  = 3'h1;
    localparam logic [2:0] CODE_DIRECT = 3'h3;

    // ****************************************************************
    // Widths and cycle counts
    // ****************************************************************
    localparam int PER_W   = 8;
    localparam int WD_W    = 5;
    localparam int WD_OVF  = 16;
    localparam int FR_W    = 3;
    localparam int FR_HALF = 4;
    localparam int MULT_W  = 5;

    typedef enum logic [1:0] {
        SRC_IDLE   = 2'b00,
        SRC_PLL    = 2'b01,
        SRC_PRESC  = 2'b10,
        SRC_DIRECT = 2'b11
    } ccms_src_t;

    // Multiplication factor of the PLL for each select code.
    function automatic logic [MULT_W-1:0] ccms_mult(input logic [2:0] code);
        case (code)
            3'h7:    ccms_mult = 5'h04;
            3'h6:    ccms_mult = 5'h03;
            3'h5:    ccms_mult = 5'h08;
            3'h4:    ccms_mult = 5'h05;
            3'h2:    ccms_mult = 5'h0A;
            3'h0:    ccms_mult = 5'h10;
            default: ccms_mult = 5'h01;
        endcase
    endfunction

    function automatic ccms_src_t ccms_src(input logic [2:0] code);
        case (code)
            CODE_PRESC:  ccms_src = SRC_PRESC;
            CODE_DIRECT: ccms_src = SRC_DIRECT;
            default:     ccms_src = SRC_PLL;
        endcase
    endfunction

endpackage

`default_nettype wire

// ==== ccms_top.sv ====
// CPU clock mode select: picks PLL, prescaler or direct drive at reset and makes the CPU clock.
`timescale 1ns/1ps
`default_nettype none

module ccms_top (
    input  wire logic       i_clk,                  // 40 MHz system clock
    input  wire logic       i_nrst,                 // Asynchronous reset, active low
    input  wire logic [2:0] i_clock_mode_select_pins, // Mode straps
    input  wire logic       i_ext_clk,              // External clock input pin level
    input  wire logic       i_osc_watchdog_disable, // Config bit 4, disables watchdog
    output logic            o_cpu_clk,              // CPU clock
    output logic            o_cpu_edge,             // Pulse on either CPU clock edge
    output logic            o_pll_on,               // PLL powered and running
    output logic            o_osc_amp_bypass,       // Oscillator amplifier bypassed
    output logic            o_owd_irq               // Sticky watchdog interrupt request
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic                          latched;
        logic [2:0]                    mode;
        ccms_pkg::ccms_src_t           src;
        logic                          owd_dis;
        logic                          ext_prev;
        logic                          rise_seen;
        logic [ccms_pkg::PER_W-1:0]    per_cnt;
        logic [ccms_pkg::PER_W-1:0]    period;
        logic [ccms_pkg::PER_W:0]      acc;
        logic [ccms_pkg::FR_W-1:0]     fr_cnt;
        logic                          fr_clk;
        logic [ccms_pkg::WD_W-1:0]     wd_cnt;
        logic                          fail;
        logic                          cpu_clk;
        logic                          cpu_edge;
        logic                          pll_on;
        logic                          bypass;
    } ccms_st_t;

    ccms_st_t q_r;
    ccms_st_t q_nxt;

    logic                       ext_rise;
    logic                       ext_tr;
    logic                       wd_en;
    logic                       pll_run;
    logic                       fr_wrap;
    logic                       fr_tick;
    logic [ccms_pkg::PER_W:0]   sum;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        q_nxt    = q_r;
        ext_rise = i_ext_clk & ~q_r.ext_prev;
        ext_tr   = i_ext_clk ^ q_r.ext_prev;
        wd_en    = (q_r.src == ccms_pkg::SRC_PRESC || q_r.src == ccms_pkg::SRC_DIRECT)
                   && !q_r.owd_dis;
        pll_run  = (q_r.src == ccms_pkg::SRC_PLL) || wd_en || q_r.fail;
        fr_wrap  = pll_run && (q_r.fr_cnt == ccms_pkg::FR_W'(ccms_pkg::FR_HALF - 1));
        fr_tick  = fr_wrap && q_r.fr_clk;
        sum      = q_r.acc + {(ccms_pkg::PER_W + 1 - ccms_pkg::MULT_W - 1)'(0),
                              ccms_pkg::ccms_mult(q_r.mode), 1'b0};

        q_nxt.ext_prev = i_ext_clk;
        q_nxt.owd_dis  = i_osc_watchdog_disable;

        // The straps are caught on the first edge after release, never again.
        if (!q_r.latched) begin
            q_nxt.latched = 1'b1;
            q_nxt.mode    = i_clock_mode_select_pins;
            q_nxt.src     = ccms_pkg::ccms_src(i_clock_mode_select_pins);
        end
        q_nxt.bypass = (q_nxt.src == ccms_pkg::SRC_DIRECT);

        // Input period in system cycles, saturating for a stopped input.
        // The first rise after reset only starts the count, because the pin level before
        // reset is unknown and a partial first period would make the accumulator run away.
        if (ext_rise && q_r.latched) begin
            q_nxt.per_cnt   = '0;
            q_nxt.rise_seen = 1'b1;
            if (q_r.rise_seen) begin
                q_nxt.period = (q_r.per_cnt == '1) ? q_r.per_cnt : q_r.per_cnt + 1'b1;
            end
        end else if (q_r.per_cnt != '1) begin
            q_nxt.per_cnt = q_r.per_cnt + 1'b1;
        end

        // Free-running oscillator, only while the PLL is on.
        if (pll_run) begin
            q_nxt.fr_cnt = fr_wrap ? '0 : q_r.fr_cnt + 1'b1;
            if (fr_wrap) begin
                q_nxt.fr_clk = ~q_r.fr_clk;
            end
        end else begin
            q_nxt.fr_cnt = '0;
            q_nxt.fr_clk = 1'b0;
        end

        // Watchdog: a lost input clock is never recovered until reset.
        if (!wd_en || ext_tr) begin
            q_nxt.wd_cnt = '0;
        end else if (fr_tick) begin
            if (q_r.wd_cnt == ccms_pkg::WD_W'(ccms_pkg::WD_OVF - 1)) begin
                q_nxt.fail = 1'b1;
            end else begin
                q_nxt.wd_cnt = q_r.wd_cnt + 1'b1;
            end
        end

        // Switching to the free-running clock waits for its own phase boundary,
        // so the first free-running phase is a full one.
        if (q_r.fail) begin
            if (fr_wrap) begin
                q_nxt.cpu_clk = ~q_r.cpu_clk;
            end
        end else begin
            case (q_r.src)
                ccms_pkg::SRC_PLL: begin
                    // Phase accumulator: 2F toggles per measured input period.
                    if (q_r.period != '0 && sum >= {1'b0, q_r.period}) begin
                        q_nxt.acc     = sum - {1'b0, q_r.period};
                        q_nxt.cpu_clk = ~q_r.cpu_clk;
                    end else if (q_r.period != '0) begin
                        q_nxt.acc = sum;
                    end
                end
                ccms_pkg::SRC_PRESC: begin
                    if (ext_rise) begin
                        q_nxt.cpu_clk = ~q_r.cpu_clk;
                    end
                end
                ccms_pkg::SRC_DIRECT: q_nxt.cpu_clk = i_ext_clk;
                default:              q_nxt.cpu_clk = 1'b0;
            endcase
        end

        q_nxt.cpu_edge = q_nxt.cpu_clk ^ q_r.cpu_clk;
        q_nxt.pll_on   = pll_run;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q_r      <= '0;
            q_r.mode <= ccms_pkg::MODE_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign o_cpu_clk        = q_r.cpu_clk;
    assign o_cpu_edge       = q_r.cpu_edge;
    assign o_pll_on         = q_r.pll_on;
    assign o_osc_amp_bypass = q_r.bypass;
    assign o_owd_irq        = q_r.fail;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    property p_mode_held;
        q_r.latched |=> $stable(q_r.mode) && $stable(q_r.src);
    endproperty
    a_mode_held: assert property (p_mode_held) else $error("mode changed after latch");

    property p_mode_from_pins;
        !q_r.latched |=> q_r.mode == $past(i_clock_mode_select_pins);
    endproperty
    a_mode_from_pins: assert property (p_mode_from_pins) else $error("strap not caught");

    property p_presc_toggle;
        q_r.src == ccms_pkg::SRC_PRESC && !q_r.fail && i_ext_clk && !q_r.ext_prev
            |=> q_r.cpu_clk != $past(q_r.cpu_clk);
    endproperty
    a_presc_toggle: assert property (p_presc_toggle) else $error("prescaler missed edge");

    property p_presc_hold;
        q_r.src == ccms_pkg::SRC_PRESC && !q_r.fail && !(i_ext_clk && !q_r.ext_prev)
            |=> $stable(q_r.cpu_clk);
    endproperty
    a_presc_hold: assert property (p_presc_hold) else $error("prescaler extra edge");

    property p_direct_follow;
        q_r.src == ccms_pkg::SRC_DIRECT && !q_r.fail |=> q_r.cpu_clk == $past(i_ext_clk);
    endproperty
    a_direct_follow: assert property (p_direct_follow) else $error("direct not following");

    property p_pll_off;
        q_r.src inside {ccms_pkg::SRC_PRESC, ccms_pkg::SRC_DIRECT} && q_r.owd_dis && !q_r.fail
            |=> !q_r.pll_on;
    endproperty
    a_pll_off: assert property (p_pll_off) else $error("PLL not off");

    property p_pll_free;
        q_r.src inside {ccms_pkg::SRC_PRESC, ccms_pkg::SRC_DIRECT} && !q_r.owd_dis
            |=> q_r.pll_on;
    endproperty
    a_pll_free: assert property (p_pll_free) else $error("PLL not free running");

    property p_wd_overflow;
        wd_en && !ext_tr && fr_tick && q_r.wd_cnt == ccms_pkg::WD_W'(ccms_pkg::WD_OVF - 1)
            |=> o_owd_irq ##1 o_owd_irq;
    endproperty
    a_wd_overflow: assert property (p_wd_overflow) else $error("watchdog did not fire");

    property p_edge_pulse;
        $changed(q_r.cpu_clk) |-> q_r.cpu_edge;
    endproperty
    a_edge_pulse: assert property (p_edge_pulse) else $error("edge pulse missing");

    property p_fr_phase;
        q_r.fail && $changed(q_r.cpu_clk) |=> $stable(q_r.cpu_clk) [*3];
    endproperty
    a_fr_phase: assert property (p_fr_phase) else $error("short free-running phase");

    property p_pll_mult;
        q_r.latched && q_r.src == ccms_pkg::SRC_PLL |=> q_r.pll_on && !q_r.bypass;
    endproperty
    a_pll_mult: assert property (p_pll_mult) else $error("PLL mode without PLL");

    c_presc:  cover property (q_r.src == ccms_pkg::SRC_PRESC && q_r.cpu_edge);
    c_direct: cover property (q_r.src == ccms_pkg::SRC_DIRECT && q_r.cpu_edge);
    c_pll:    cover property (q_r.src == ccms_pkg::SRC_PLL && q_r.cpu_edge);
    c_fail:   cover property ($rose(o_owd_irq));

endmodule // ccms_top

`default_nettype wire

// ==== ccms_xtal_model.sv ====
// Behavioural crystal oscillator that drives the external clock input pin.
`timescale 1ns/1ps
`default_nettype none

module ccms_xtal_model (
    input  wire logic       i_clk,    // Bench clock, pin changes at its rising edge
    input  wire logic [7:0] i_period, // Input clock period in bench cycles
    input  wire logic [7:0] i_high,   // High phase in bench cycles
    input  wire logic       i_run,    // Oscillator running
    output logic            o_ext     // External clock input pin level
);
    // ****************************************************************
    // Oscillator
    // ****************************************************************
    logic [7:0] cnt = 8'h00;

    // A failed crystal freezes at its last level, which is what the watchdog has to catch.
    // The pin moves by non-blocking assignment on the rising edge, so it never races the
    // bench, which changes the controls at the falling edge.
    always @(posedge i_clk) begin
        if (i_run) begin
            cnt <= (cnt + 8'h01 >= i_period) ? 8'h00 : cnt + 8'h01;
        end
    end

    assign o_ext = (cnt < i_high);
endmodule // ccms_xtal_model

`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the CPU clock mode select block.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // ****************************************************************
    // Stimulus, partner and design
    // ****************************************************************
    logic       clk    = 1'b0;
    logic       nrst   = 1'b0;
    logic [2:0] pins   = 3'h7;
    logic       wd_dis = 1'b0;
    logic       run    = 1'b0;
    logic [7:0] per    = 8'h28;
    logic [7:0] hi     = 8'h14;
    logic       ext, cpu, edg, pll, byp, irq;
    int         n_fail = 0;
    int         check_count = 0;
    int         tog, hmin, hmax, ebad, k, f;

    always #12.5 clk = ~clk;

    ccms_xtal_model i_src (.i_clk(clk), .i_period(per), .i_high(hi), .i_run(run), .o_ext(ext));
    ccms_top i_dut (.i_clk(clk), .i_nrst(nrst), .i_clock_mode_select_pins(pins),
        .i_ext_clk(ext), .i_osc_watchdog_disable(wd_dis), .o_cpu_clk(cpu),
        .o_cpu_edge(edg), .o_pll_on(pll), .o_osc_amp_bypass(byp), .o_owd_irq(irq));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic int mult(input logic [2:0] code);
        case (code)
            3'h7: return 4;
            3'h6: return 3;
            3'h5: return 8;
            3'h4: return 5;
            3'h2: return 10;
            default: return 16;
        endcase
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0d seen %0d", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // The straps move after capture so that a mode that is not latched shows up at once.
    task automatic start(input logic [2:0] code, input logic dis);
        @(negedge clk);
        nrst = 1'b0;
        run = 1'b0;
        pins = code;
        wd_dis = dis;
        repeat (8) @(negedge clk);
        check("reset_outputs", {cpu, edg, pll, byp, irq}, 0);
        nrst = 1'b1;
        run = 1'b1;
        repeat (2) @(negedge clk);
        pins = ~code;
    endtask

    // The first half period seen is partial, so it is left out of the extremes.
    task automatic measure(input int n);
        logic prev;
        int   len;
        prev = cpu;
        len = 0;
        tog = 0;
        hmin = 999;
        hmax = 0;
        ebad = 0;
        repeat (n) begin
            @(negedge clk);
            len++;
            if (edg !== (cpu !== prev)) begin
                ebad++;
            end
            if (cpu !== prev) begin
                if (tog > 0) begin
                    hmin = (len < hmin) ? len : hmin;
                    hmax = (len > hmax) ? len : hmax;
                end
                tog++;
                len = 0;
            end
            prev = cpu;
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        void'($urandom(55));
        for (k = 0; k < 8; k++) begin
            if (k == 1 || k == 3) begin
                continue;
            end
            start(k[2:0], 1'b0);
            repeat (120) @(negedge clk);
            measure(160);
            f = mult(k[2:0]);
            check("pll_rate", tog >= 8 * f - 2 && tog <= 8 * f + 2, 1);
            check("pll_bypass", byp, 0);
            check("pll_running", pll, 1);
            check("pll_edge", ebad, 0);
        end
        for (k = 0; k < 6; k++) begin
            per = 8'($urandom_range(20, 4));
            hi = 8'($urandom_range(per - 1, 1));
            start(k[0] ? 3'h3 : 3'h1, k[1]);
            repeat (2 * per + 4) @(negedge clk);
            measure(8 * per);
            if (k[0]) begin
                check("direct_min", hmin, (hi < per - hi) ? hi : per - hi);
                check("direct_sum", hmin + hmax, per);
            end else begin
                check("presc_min", hmin, per);
                check("presc_max", hmax, per);
            end
            check("bypass", byp, k[0]);
            check("pll_on", pll, !k[1]);
            check("edge", ebad, 0);
        end
        per = 8'h0A;
        hi = 8'h05;
        start(3'h3, 1'b0);
        repeat (60) @(negedge clk);
        run = 1'b0;
        k = 0;
        while (irq !== 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
        end
        check("owd_delay", k >= 112 && k <= 140, 1);
        if (k < 200) begin
            measure(64);
            check("owd_half", hmin + hmax, 8);
            check("owd_edge", ebad, 0);
            run = 1'b1;
            measure(64);
            check("owd_stays", hmax, 4);
            check("owd_irq_held", irq, 1);
        end
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
